// ===== hw/pcs_pkg.sv
// package: layout and constants of the bus event status register
// Contract
// - Bit 15 sets on any detected parity error, even with response off.
// - Bit 14 sets each time the device drives the system error line.
// - Bit 13 sets on master abort of an own non-special master cycle.
// - Bit 12 sets when an own master cycle is ended by target abort.
// - Bit 11 sets when the device as target signals target abort.
// - Select timing is fast 00b, medium 01b, slow 10b; here medium.
// - Bits 10 to 9 are read-only and give the slowest non-config timing.
// - Bit 8 sets only as master, on read or write PERR#, with response on.
// - Fast-back-to-back-capable bit 7 is read-only and reads 0.
// - Bit 5 is read-only bus speed capability and reads 0, 33 MHz only.
// - The 16-bit status register at offset 06h is read-only from the bus.
// - Capabilities-list bit 4 is read-only and reads 1, list at 34h; here 34h is not decoded and answers zero with hit low.
package pcs_pkg;

  localparam logic [7:0] PCS_STATUS_OFFSET = 8'h06;
  localparam logic [7:0] PCS_CAP_PTR_OFFSET = 8'h34;

  localparam int PCS_BIT_PARITY_ERR = 15;
  localparam int PCS_BIT_SYS_ERR = 14;
  localparam int PCS_BIT_MASTER_ABORT = 13;
  localparam int PCS_BIT_TARGET_ABORT_RX = 12;
  localparam int PCS_BIT_TARGET_ABORT_TX = 11;
  localparam int PCS_BIT_DEVSEL_HI = 10;
  localparam int PCS_BIT_DEVSEL_LO = 9;
  localparam int PCS_BIT_MASTER_PARITY = 8;
  localparam int PCS_BIT_FBB = 7;
  localparam int PCS_BIT_66M = 5;
  localparam int PCS_BIT_CAPL = 4;

  localparam logic [1:0] PCS_DEVSEL_FAST = 2'h0;
  localparam logic [1:0] PCS_DEVSEL_MEDIUM = 2'h1;
  localparam logic [1:0] PCS_DEVSEL_SLOW = 2'h2;

  localparam logic PCS_FLAG_RESET = 1'h0;
  localparam logic [15:0] PCS_STATUS_RESET = 16'h0210;
  localparam logic PCS_FBB_VALUE = 1'h0;
  localparam logic PCS_66M_VALUE = 1'h0;
  localparam logic PCS_CAPL_VALUE = 1'h1;

endpackage

// ===== hw/pcs_sticky_flag.sv
// one sticky event flag, set by hardware, cleared only by reset
`timescale 1ns/1ns
module pcs_sticky_flag
  import pcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic setEvent,
  output logic flag
);

  typedef struct packed {
    logic flag;
  } pcs_flag_s;

  pcs_flag_s stateQ;
  pcs_flag_s stateD;

  always_comb
  begin
    stateD = stateQ;
    if (setEvent)
    begin
      stateD.flag = 1'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stateQ.flag <= PCS_FLAG_RESET;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  assign flag = stateQ.flag;

endmodule

// ===== hw/pcs_cfg_read_port.sv
// configuration read port: decodes offset, registers read answer
`timescale 1ns/1ns
module pcs_cfg_read_port
  import pcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [15:0] statusWord,
  output logic [15:0] cfgRdData,
  output logic cfgRdValid,
  output logic cfgRdHit
);

  typedef struct packed {
    logic [15:0] data;
    logic valid;
    logic hit;
  } pcs_rd_s;

  pcs_rd_s stateQ;
  pcs_rd_s stateD;

  always_comb
  begin
    stateD = stateQ;
    stateD.valid = cfgRead;
    stateD.hit = 1'h0;
    if (cfgRead)
    begin
      // unmapped offsets answer zero with hit low
      stateD.data = 16'h0000;
      if (cfgAddr == PCS_STATUS_OFFSET)
      begin
        stateD.data = statusWord;
        stateD.hit = 1'h1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stateQ <= '0;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  assign cfgRdData = stateQ.data;
  assign cfgRdValid = stateQ.valid;
  assign cfgRdHit = stateQ.hit;

endmodule

// ===== hw/pcs_status.sv
// bus event status register of the configuration header
`timescale 1ns/1ns
module pcs_status
  import pcs_pkg::*;
#(
  parameter logic [1:0] DEVSEL_TIMING = PCS_DEVSEL_MEDIUM
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic parityErrDetected,
  input wire logic serrDriven,
  input wire logic masterAbortRcvd,
  input wire logic specialCycle,
  input wire logic targetAbortRcvd,
  input wire logic targetAbortSignalled,
  input wire logic actingMaster,
  input wire logic perrDrivenOnRead,
  input wire logic perrSeenOnWrite,
  input wire logic parity_err_response_en,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  output logic [15:0] cfgRdData,
  output logic cfgRdValid,
  output logic cfgRdHit,
  output logic [15:0] statusWordQ
);

  localparam int NFLAG = 6;

  typedef struct packed {
    logic [15:0] word;
  } pcs_top_s;

  pcs_top_s stateQ;
  pcs_top_s stateD;
  logic [NFLAG-1:0] flagSet;
  logic [NFLAG-1:0] flag;
  logic [15:0] statusWord;

  // flag order: parity, system, master abort, target abort rx/tx, master parity
  always_comb
  begin
    flagSet[5] = parityErrDetected;
    flagSet[4] = serrDriven;
    flagSet[3] = masterAbortRcvd & ~specialCycle;
    flagSet[2] = targetAbortRcvd;
    flagSet[1] = targetAbortSignalled;
    flagSet[0] = actingMaster & parity_err_response_en
      & (perrDrivenOnRead | perrSeenOnWrite);
  end

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++)
    begin : gFlag
      pcs_sticky_flag uFlag (
        .ref_clk(ref_clk),
        .rst(rst),
        .setEvent(flagSet[gi]),
        .flag(flag[gi])
      );
    end
  endgenerate

  always_comb
  begin
    statusWord = 16'h0000;
    statusWord[PCS_BIT_PARITY_ERR] = flag[5];
    statusWord[PCS_BIT_SYS_ERR] = flag[4];
    statusWord[PCS_BIT_MASTER_ABORT] = flag[3];
    statusWord[PCS_BIT_TARGET_ABORT_RX] = flag[2];
    statusWord[PCS_BIT_TARGET_ABORT_TX] = flag[1];
    statusWord[PCS_BIT_DEVSEL_HI:PCS_BIT_DEVSEL_LO] =
      DEVSEL_TIMING;
    statusWord[PCS_BIT_MASTER_PARITY] = flag[0];
    statusWord[PCS_BIT_FBB] = PCS_FBB_VALUE;
    statusWord[PCS_BIT_66M] = PCS_66M_VALUE;
    statusWord[PCS_BIT_CAPL] = PCS_CAPL_VALUE;
  end

  always_comb
  begin
    stateD = stateQ;
    stateD.word = statusWord;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stateQ.word <= PCS_STATUS_RESET;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  assign statusWordQ = stateQ.word;

  // no write path: the register is read-only from the bus
  pcs_cfg_read_port uRead (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfgRead(cfgRead),
    .cfgAddr(cfgAddr),
    .statusWord(statusWord),
    .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid),
    .cfgRdHit(cfgRdHit)
  );

endmodule

// ===== testbench/pcs_status_asserts.sv
// checker of the bus event status register ports
`timescale 1ns/1ns
module pcs_status_asserts
  import pcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic parityErrDetected,
  input wire logic serrDriven,
  input wire logic masterAbortRcvd,
  input wire logic specialCycle,
  input wire logic targetAbortRcvd,
  input wire logic targetAbortSignalled,
  input wire logic actingMaster,
  input wire logic perrDrivenOnRead,
  input wire logic perrSeenOnWrite,
  input wire logic parity_err_response_en,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [15:0] cfgRdData,
  input wire logic cfgRdValid,
  input wire logic cfgRdHit,
  input wire logic [15:0] statusWordQ
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  fixed_bits_a: assert property (
    (statusWordQ[10:0] & 11'h6FF) == 11'h210)
    else $error("fixed bits wrong");
  parity_set_a: assert property (
    parityErrDetected |-> ##2 statusWordQ[15])
    else $error("bit15 not set");
  serr_set_a: assert property (
    serrDriven |-> ##2 statusWordQ[14])
    else $error("bit14 not set");
  mabort_set_a: assert property (
    masterAbortRcvd && !specialCycle |-> ##2 statusWordQ[13])
    else $error("bit13 not set");
  mabort_cause_a: assert property (
    $rose(statusWordQ[13]) |->
      $past(masterAbortRcvd && !specialCycle, 2))
    else $error("bit13 set without cause");
  tabort_set_a: assert property (
    targetAbortRcvd |-> ##2 statusWordQ[12])
    else $error("bit12 not set");
  tabort_tx_a: assert property (
    targetAbortSignalled |-> ##2 statusWordQ[11])
    else $error("bit11 not set");
  mparity_cause_a: assert property (
    $rose(statusWordQ[8]) |->
      $past(actingMaster && parity_err_response_en &&
        (perrDrivenOnRead || perrSeenOnWrite), 2))
    else $error("bit8 set without cause");
  read_answer_a: assert property (
    cfgRead |=> cfgRdValid &&
      (cfgRdHit == ($past(cfgAddr) == PCS_STATUS_OFFSET)))
    else $error("read answer wrong");
  read_data_a: assert property (
    cfgRdValid |-> cfgRdData == (cfgRdHit ? statusWordQ : 16'h0000))
    else $error("read data wrong");
endmodule
bind pcs_status pcs_status_asserts chk (.*);

// ===== testbench/pcs_bus_agent.sv
// far-side bus agent model: one cycle of event lines per request
`timescale 1ns/1ns
module pcs_bus_agent
(
  input wire logic ref_clk,
  input wire logic [9:0] req,
  output logic [9:0] lines
);
  initial lines = 10'h000;
  always @(negedge ref_clk)
    lines <= req;
endmodule

// ===== testbench/test_pcs_status.sv
// self-checking bench of the bus event status register
`timescale 1ns/1ns
module test_pcs_status
  import pcs_pkg::*;
;
  logic ref_clk = 1'h0, rst = 1'h1, cfgRead = 1'h0;
  logic [7:0] cfgAddr = 8'h00;
  logic [9:0] req = 10'h000, ev;
  logic [15:0] cfgRdData, statusWordQ, expWord, r;
  logic cfgRdValid, cfgRdHit;
  logic [32:0] note;
  logic [32:0] q[$];
  int nErrors = 0, checksDone = 0, cyc = 0, seed = 35;
  pcs_bus_agent agent (.ref_clk(ref_clk), .req(req), .lines(ev));
  pcs_status uut (.ref_clk(ref_clk), .rst(rst), .parityErrDetected(ev[9]),
    .serrDriven(ev[8]), .masterAbortRcvd(ev[7]), .specialCycle(ev[6]),
    .targetAbortRcvd(ev[5]), .targetAbortSignalled(ev[4]),
    .actingMaster(ev[3]), .perrDrivenOnRead(ev[2]), .perrSeenOnWrite(ev[1]),
    .parity_err_response_en(ev[0]), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgRdHit(cfgRdHit),
    .statusWordQ(statusWordQ));
  initial forever #5 ref_clk = ~ref_clk;
  task check(input logic [15:0] seen, input logic [15:0] want);
    checksDone++;
    if (seen !== want)
    begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task printVerdict;
    $display("errors=%0d checks=%0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // note: expected hit, expected read data, expected status word
  task rd(input logic [7:0] a);
    cfgRead <= 1'h1;
    cfgAddr <= a;
    q.push_back({a == PCS_STATUS_OFFSET,
      a == PCS_STATUS_OFFSET ? expWord : 16'h0000, expWord});
    @(negedge ref_clk);
  endtask
  always @(negedge ref_clk)
  begin
    cyc++;
    if (cfgRdValid === 1'h1)
    begin
      note = q.pop_front();
      check(cfgRdData, note[31:16]);
      check({15'h0, cfgRdHit}, {15'h0, note[32]});
      check(statusWordQ, note[15:0]);
    end
    if (cyc == 5000)
    begin
      nErrors++;
      printVerdict();
    end
  end
  initial
  begin
    expWord = PCS_STATUS_RESET;
    repeat (10) @(negedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    for (int i = 0; i < 300; i++)
    begin
      r = $random(seed);
      rd(PCS_STATUS_OFFSET);
      rd(r[15:8]);
      cfgRead <= 1'h0;
      req <= r[9:0];
      @(negedge ref_clk);
      req <= 10'h000;
      @(negedge ref_clk);
      expWord[15:14] = expWord[15:14] | r[9:8];
      expWord[13] = expWord[13] | (r[7] & ~r[6]);
      expWord[12:11] = expWord[12:11] | r[5:4];
      expWord[8] = expWord[8] | (r[3] & r[0] & (r[2] | r[1]));
      if (i % 16 == 15)
      begin
        rst <= 1'h1;
        repeat (2) @(negedge ref_clk);
        rst <= 1'h0;
        expWord = PCS_STATUS_RESET;
        @(negedge ref_clk);
      end
    end
    repeat (3) @(negedge ref_clk);
    printVerdict();
  end
endmodule
